/* verilog/telephone_dialer.sv */
// Telephone dialing sequencer: DTMF tone and loop-disconnect pulse dialing with mutes.
// Assumes a single-master AHB-Lite bus on mclk; line pins are synchronous to mclk.
//
// Contract
// RULE_01: A tone cycle is tone-on then silent gap, then the dialing interrupt.
// RULE_02: The tone inter-digit gap is always 94 ms.
// RULE_03: With tone hold clear, the tone lasts exactly 94 ms.
// RULE_04: With tone hold set, tone runs until cleared, never under 94 ms.
// RULE_05: Reset clears tone hold.
// RULE_06: Software enables the fast oscillator and waits 5 ms before tone dialing.
// RULE_07: Configure first; writing the dial code starts a dialing cycle.
// RULE_08: Dual tone picks row and column from the code map.
// RULE_09: Column enable alone gives only the mapped column tone.
// RULE_10: Row enable alone gives only the mapped row tone.
// RULE_11: Tone output carries the tone; transmit mute low through tone and gap.
// RULE_12: Driven mutes stay low about 4 ms after the gap ends.
// RULE_13: Software selects pulse method before writing the code.
// RULE_14: Make/break bit: 1 gives 33.3:66.6, 0 gives 40:60; reset 40:60.
// RULE_15: Rate bit: 1 gives 20 pps, 0 gives 10 pps; reset 10 pps.
// RULE_16: A pulse cycle is pulse train then selected gap, then the interrupt.
// RULE_17: Gap code 1..F selects 94..1406 ms; code 0 must not be written.
// RULE_18: Pulse code N gives exactly N pulses; code 0 must not be written.
// RULE_19: Each pulse is make first, break second.
// RULE_20: Both mutes low during the pulse train and the pulse gap.
// RULE_21: Cycle end sets the done flag; reading clears it; no start while set.
// RULE_22: Hook bit drives the pulse pin high off-hook; reset on-hook.
// RULE_23: Row and column enables gate their tones; both clear gives mid level.
// RULE_24: Clearing a mute permission forces that mute low; reset sets both.
// RULE_25: All millisecond intervals count ticks of the low-speed timebase.
`timescale 1ns/100ps
`default_nettype none

module telephone_dialer
  import dialer_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic mclk,            // System clock, 100 MHz
  input wire logic rst_n,           // Asynchronous reset, active low
  input wire logic hsel,            // AHB slave select
  input wire logic [31:0] haddr,    // AHB address
  input wire logic [1:0] htrans,    // AHB transfer type
  input wire logic hwrite,          // AHB write
  input wire logic [2:0] hsize,     // AHB size
  input wire logic [31:0] hwdata,   // AHB write data
  input wire logic hready,          // AHB bus ready
  output logic hreadyout,           // AHB slave ready
  output logic hresp,               // AHB response, always OKAY
  output logic [31:0] hrdata,       // AHB read data
  output logic [7:0] tone_out,      // Tone sample, mid level when silent
  output logic pulse_dial_out,      // Loop pin, high off-hook
  output logic rx_mute_n,           // Receive mute, active low
  output logic tx_mute_n,           // Transmit mute, active low
  output logic fast_oscillator_en,  // Request for the tone oscillator
  output logic dial_irq             // Dialing interrupt request
);

  // Timebase divider is 17 bits wide
  if (TICK_CYCLES_P < 2 || TICK_CYCLES_P > 131071) begin : g_tick_range
    $error("TICK_CYCLES_P out of range");
  end

  typedef struct packed {
    ctl_regs_t r;
    dial_state_t st;
    logic [16:0] div;
    logic [10:0] ms;
    logic [3:0] pulses_left;
    logic [10:0] gap_ms;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    logic [16:0] row_cnt;
    logic [16:0] col_cnt;
    logic row_ph;
    logic col_ph;
    logic [7:0] tone;
    logic pdo;
    logic rx_n;
    logic tx_n;
    logic irq;
    logic tail_rx;
  } state_t;

  state_t q, d;

  function automatic logic [1:0] row_of(input logic [3:0] code);
    logic [1:0] r;
    r = 2'd0;
    unique case (code)
      4'h0, 4'h1, 4'h2, 4'h3: r = 2'd0;
      4'h4, 4'h5, 4'h6, 4'hd: r = 2'd1;
      4'h7, 4'h8, 4'h9, 4'hf: r = 2'd2;
      4'ha, 4'hb, 4'hc, 4'he: r = 2'd3;
    endcase
    return r;
  endfunction : row_of

  function automatic logic [1:0] col_of(input logic [3:0] code);
    logic [1:0] c;
    c = 2'd0;
    unique case (code)
      4'h1, 4'h4, 4'h7, 4'hc: c = 2'd0;
      4'h2, 4'h5, 4'h8, 4'ha: c = 2'd1;
      4'h3, 4'h6, 4'h9, 4'hb: c = 2'd2;
      4'h0, 4'hd, 4'he, 4'hf: c = 2'd3;
    endcase
    return c;
  endfunction : col_of

  // Gap code times 93.75 ms, rounded, matches the printed 94..1406 ms steps
  function automatic logic [10:0] gap_ms_of(input logic [3:0] code);
    logic [12:0] x4;
    x4 = 13'(code) * GAP_STEP_X4 + 13'd2;
    return x4[12:2];
  endfunction : gap_ms_of

  function automatic logic [10:0] make_ms_of(input logic rate, input logic mb);
    logic [10:0] m;
    m = MAKE_10PPS_40_MS;
    unique case ({rate, mb})
      2'b00: m = MAKE_10PPS_40_MS;
      2'b01: m = MAKE_10PPS_33_MS;
      2'b10: m = MAKE_20PPS_40_MS;
      2'b11: m = MAKE_20PPS_33_MS;
    endcase
    return m;
  endfunction : make_ms_of

  logic addr_ok;
  logic [7:0] a_idx;
  logic tick;
  logic start;
  logic cycle_end;
  logic rd_clear;
  logic [10:0] make_ms;
  logic [10:0] period_ms;
  logic tone_active;
  logic pulse_mute;
  logic tx_mute_act;
  logic rx_mute_act;
  logic [1:0] row_sel;
  logic [1:0] col_sel;
  logic [7:0] tone_sum;

  always_comb begin
    d = q;
    addr_ok = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
    a_idx = haddr[9:2];
    start = 1'b0;
    cycle_end = 1'b0;
    rd_clear = 1'b0;
    tick = q.div == 17'(TICK_CYCLES_P - 1);
    make_ms = make_ms_of(q.r.pulse_rate_sel, q.r.make_break_sel); // [RULE_14] [RULE_15]
    period_ms = q.r.pulse_rate_sel ? PERIOD_20PPS_MS : PERIOD_10PPS_MS; // [RULE_15]

    // Free-running timebase; rearmed at each start so intervals are whole ticks
    d.div = tick ? 17'd0 : q.div + 17'd1; // [RULE_25]
    if (tick) begin
      d.ms = q.ms + 11'd1; // [RULE_25]
    end

    // Data phase of a write
    d.wr_pend = 1'b0;
    if (q.wr_pend) begin
      unique case (q.wr_idx)
        IDX_IRQ_MASK: d.r.dial_irq_mask = hwdata[0];
        IDX_OSC_CTL: d.r.fast_osc_on = hwdata[0];
        IDX_DIAL_MODE: begin
          d.r.dial_method_sel = hwdata[BIT_METHOD];
          d.r.make_break_sel = hwdata[BIT_MAKE_BREAK];
          d.r.pulse_rate_sel = hwdata[BIT_RATE];
        end
        IDX_PULSE_GAP: d.r.pulse_gap_select = hwdata[3:0]; // [RULE_17]
        IDX_TONE_EN: begin
          d.r.row_tone_en = hwdata[BIT_ROW_EN];
          d.r.col_tone_en = hwdata[BIT_COL_EN];
        end
        IDX_DIAL_CODE: begin
          d.r.dial_code = hwdata[3:0];
          // Refused while busy or while the done flag is unread
          start = !q.r.dial_done_flag && (q.st == ST_IDLE || q.st == ST_TAIL); // [RULE_07] [RULE_21]
        end
        IDX_MUTE_ALLOW: begin
          d.r.rx_mute_allow = hwdata[BIT_RX_ALLOW];
          d.r.tx_mute_allow = hwdata[BIT_TX_ALLOW];
        end
        IDX_HOOK: d.r.hook_off_ctl = hwdata[0];
        IDX_TONE_HOLD: d.r.tone_hold_ctl = hwdata[BIT_TONE_HOLD];
        default: ;
      endcase
    end

    // Address phase: latch writes, prepare read data for the data phase
    d.rdata = 32'h0000_0000;
    if (addr_ok && hwrite) begin
      d.wr_pend = 1'b1;
      d.wr_idx = a_idx;
    end else if (addr_ok) begin
      unique case (a_idx)
        IDX_DONE_FLAG: begin
          d.rdata[0] = q.r.dial_done_flag;
          rd_clear = 1'b1; // [RULE_21]
        end
        IDX_IRQ_MASK: d.rdata[0] = q.r.dial_irq_mask;
        IDX_OSC_CTL: d.rdata[0] = q.r.fast_osc_on;
        IDX_DIAL_MODE: begin
          d.rdata[BIT_METHOD] = q.r.dial_method_sel;
          d.rdata[BIT_MAKE_BREAK] = q.r.make_break_sel;
          d.rdata[BIT_RATE] = q.r.pulse_rate_sel;
        end
        IDX_PULSE_GAP: d.rdata[3:0] = q.r.pulse_gap_select;
        IDX_TONE_EN: begin
          d.rdata[BIT_ROW_EN] = q.r.row_tone_en;
          d.rdata[BIT_COL_EN] = q.r.col_tone_en;
        end
        IDX_DIAL_CODE: d.rdata[3:0] = q.r.dial_code;
        IDX_MUTE_ALLOW: begin
          d.rdata[BIT_RX_ALLOW] = q.r.rx_mute_allow;
          d.rdata[BIT_TX_ALLOW] = q.r.tx_mute_allow;
        end
        IDX_HOOK: d.rdata[0] = q.r.hook_off_ctl;
        IDX_TONE_HOLD: d.rdata[BIT_TONE_HOLD] = q.r.tone_hold_ctl;
        default: d.rdata = 32'h0000_0000;
      endcase
    end

    // Dialing sequencer
    unique case (q.st)
      ST_IDLE: ;
      ST_TONE: begin
        // Hold can only lengthen the tone past the minimum
        if (q.ms >= TONE_MIN_MS && !q.r.tone_hold_ctl) begin // [RULE_03] [RULE_04]
          d.st = ST_TGAP;
          d.ms = 11'd0;
        end
      end
      ST_TGAP: begin
        if (q.ms >= TONE_GAP_MS) begin // [RULE_02]
          cycle_end = 1'b1; // [RULE_01]
          d.st = ST_TAIL;
          d.ms = 11'd0;
        end
      end
      ST_PMAKE: begin
        if (q.ms >= make_ms) begin // [RULE_19]
          d.st = ST_PBREAK;
          d.ms = 11'd0;
        end
      end
      ST_PBREAK: begin
        if (q.ms >= period_ms - make_ms) begin
          d.ms = 11'd0;
          d.pulses_left = q.pulses_left - 4'd1;
          d.st = (q.pulses_left == 4'd1) ? ST_PGAP : ST_PMAKE; // [RULE_18]
        end
      end
      ST_PGAP: begin
        if (q.ms >= q.gap_ms) begin // [RULE_17]
          cycle_end = 1'b1; // [RULE_16]
          d.st = ST_TAIL;
          d.ms = 11'd0;
        end
      end
      ST_TAIL: begin
        if (q.ms >= MUTE_TAIL_MS) begin // [RULE_12]
          d.st = ST_IDLE;
        end
      end
      default: d.st = ST_IDLE;
    endcase

    if (start) begin
      d.ms = 11'd0;
      d.div = 17'd0;
      d.pulses_left = hwdata[3:0];
      d.gap_ms = gap_ms_of(q.r.pulse_gap_select);
      d.st = q.r.dial_method_sel ? ST_PMAKE : ST_TONE;
      d.tail_rx = q.r.dial_method_sel;
    end

    // Set beats a clear in the same cycle
    d.r.dial_done_flag = cycle_end || (q.r.dial_done_flag && !rd_clear); // [RULE_21]

    // Tone generation
    tone_active = q.st == ST_TONE && q.r.fast_osc_on;
    row_sel = row_of(q.r.dial_code); // [RULE_08]
    col_sel = col_of(q.r.dial_code); // [RULE_08]
    if (!tone_active) begin
      d.row_cnt = 17'd0;
      d.col_cnt = 17'd0;
      d.row_ph = 1'b0;
      d.col_ph = 1'b0;
    end else begin
      d.row_cnt = q.row_cnt + 17'd1;
      d.col_cnt = q.col_cnt + 17'd1;
      if (q.row_cnt >= ROW_HALF[row_sel] - 17'd1) begin
        d.row_cnt = 17'd0;
        d.row_ph = !q.row_ph;
      end
      if (q.col_cnt >= COL_HALF[col_sel] - 17'd1) begin
        d.col_cnt = 17'd0;
        d.col_ph = !q.col_ph;
      end
    end
    tone_sum = TONE_MID - (q.r.row_tone_en ? TONE_SWING : 8'h00)
             - (q.r.col_tone_en ? TONE_SWING : 8'h00);
    if (q.r.row_tone_en && q.row_ph) begin
      tone_sum = tone_sum + 8'(TONE_SWING * 2); // [RULE_10] [RULE_23]
    end
    if (q.r.col_tone_en && q.col_ph) begin
      tone_sum = tone_sum + 8'(TONE_SWING * 2); // [RULE_09] [RULE_23]
    end
    d.tone = tone_active ? tone_sum : TONE_MID; // [RULE_11] [RULE_23]

    // Line and mute pins
    pulse_mute = q.st == ST_PMAKE || q.st == ST_PBREAK || q.st == ST_PGAP;
    tx_mute_act = pulse_mute || q.st == ST_TONE || q.st == ST_TGAP
                || q.st == ST_TAIL; // [RULE_11] [RULE_12] [RULE_20]
    // Tail keeps whichever mutes the finished cycle had driven
    rx_mute_act = pulse_mute || (q.st == ST_TAIL && q.tail_rx); // [RULE_12] [RULE_20]
    // A cleared permission pulls the pin low whatever the sequencer does
    d.tx_n = q.r.tx_mute_allow && !tx_mute_act; // [RULE_24]
    d.rx_n = q.r.rx_mute_allow && !rx_mute_act; // [RULE_24]
    d.pdo = q.r.hook_off_ctl && q.st != ST_PBREAK; // [RULE_22] [RULE_19]
    d.irq = q.r.dial_done_flag && q.r.dial_irq_mask;
  end

  // Reset leaves the line on-hook, mutes released and the tone pin at rest
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q.r.dial_method_sel <= 1'b0;
      q.r.make_break_sel <= 1'b0; // [RULE_14]
      q.r.pulse_rate_sel <= 1'b0; // [RULE_15]
      q.r.pulse_gap_select <= RST_PULSE_GAP;
      q.r.row_tone_en <= 1'b1;
      q.r.col_tone_en <= 1'b1;
      q.r.dial_code <= RST_DIAL_CODE;
      q.r.rx_mute_allow <= 1'b1; // [RULE_24]
      q.r.tx_mute_allow <= 1'b1; // [RULE_24]
      q.r.hook_off_ctl <= 1'b0; // [RULE_22]
      q.r.tone_hold_ctl <= 1'b0; // [RULE_05]
      q.r.fast_osc_on <= 1'b0;
      q.r.dial_irq_mask <= 1'b0;
      q.r.dial_done_flag <= 1'b0;
      q.st <= ST_IDLE;
      q.div <= 17'd0;
      q.ms <= 11'd0;
      q.pulses_left <= 4'd0;
      q.gap_ms <= 11'd0;
      q.wr_pend <= 1'b0;
      q.wr_idx <= 8'h00;
      q.rdata <= 32'h0000_0000;
      q.row_cnt <= 17'd0;
      q.col_cnt <= 17'd0;
      q.row_ph <= 1'b0;
      q.col_ph <= 1'b0;
      q.tone <= TONE_MID;
      q.pdo <= 1'b0;
      q.rx_n <= 1'b1;
      q.tx_n <= 1'b1;
      q.irq <= 1'b0;
      q.tail_rx <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // No wait states: every register answers in its data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign tone_out = q.tone;
  assign pulse_dial_out = q.pdo;
  assign rx_mute_n = q.rx_n;
  assign tx_mute_n = q.tx_n;
  assign fast_oscillator_en = q.r.fast_osc_on;
  assign dial_irq = q.irq;

endmodule : telephone_dialer

`default_nettype wire

/* verilog/dialer_pkg.sv */
// Constants, register map and types for the telephone dialing sequencer.
// Assumes a 100 MHz system clock; all dial timing derives from a 1 ms timebase tick.
package dialer_pkg;

  // Clock and timebase
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

  // Dial timing in milliseconds
  localparam logic [10:0] TONE_MIN_MS = 11'd94;
  localparam logic [10:0] TONE_GAP_MS = 11'd94;
  localparam logic [10:0] MUTE_TAIL_MS = 11'd4;
  localparam logic [10:0] PERIOD_10PPS_MS = 11'd100;
  localparam logic [10:0] PERIOD_20PPS_MS = 11'd50;
  localparam logic [10:0] MAKE_10PPS_40_MS = 11'd40;
  localparam logic [10:0] MAKE_10PPS_33_MS = 11'd33;
  localparam logic [10:0] MAKE_20PPS_40_MS = 11'd20;
  localparam logic [10:0] MAKE_20PPS_33_MS = 11'd17;
  localparam logic [12:0] GAP_STEP_X4 = 13'd375;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DONE_FLAG = 8'hc5;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hd2;
  localparam logic [7:0] IDX_OSC_CTL = 8'hd8;
  localparam logic [7:0] IDX_DIAL_MODE = 8'he0;
  localparam logic [7:0] IDX_PULSE_GAP = 8'he5;
  localparam logic [7:0] IDX_TONE_EN = 8'he6;
  localparam logic [7:0] IDX_DIAL_CODE = 8'he7;
  localparam logic [7:0] IDX_MUTE_ALLOW = 8'he8;
  localparam logic [7:0] IDX_HOOK = 8'he9;
  localparam logic [7:0] IDX_TONE_HOLD = 8'heb;

  // Field positions
  localparam int BIT_METHOD = 3;
  localparam int BIT_MAKE_BREAK = 1;
  localparam int BIT_RATE = 0;
  localparam int BIT_ROW_EN = 1;
  localparam int BIT_COL_EN = 0;
  localparam int BIT_RX_ALLOW = 1;
  localparam int BIT_TX_ALLOW = 0;
  localparam int BIT_TONE_HOLD = 3;

  // Reset values
  localparam logic [3:0] RST_PULSE_GAP = 4'h8;
  localparam logic [3:0] RST_DIAL_CODE = 4'h0;

  // Tone output levels, 8-bit sample around mid-supply
  localparam logic [7:0] TONE_MID = 8'h80;
  localparam logic [7:0] TONE_SWING = 8'h30;

  // Half periods of the tone square waves in system clock cycles
  localparam logic [16:0] ROW_HALF [4] = '{17'd71736, 17'd64935, 17'd58685, 17'd53135};
  localparam logic [16:0] COL_HALF [4] = '{17'd41356, 17'd37425, 17'd33852, 17'd30618};

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TONE = 3'b001,
    ST_TGAP = 3'b011,
    ST_TAIL = 3'b010,
    ST_PMAKE = 3'b110,
    ST_PBREAK = 3'b111,
    ST_PGAP = 3'b101
  } dial_state_t;

  typedef struct packed {
    logic dial_method_sel;
    logic make_break_sel;
    logic pulse_rate_sel;
    logic [3:0] pulse_gap_select;
    logic row_tone_en;
    logic col_tone_en;
    logic [3:0] dial_code;
    logic rx_mute_allow;
    logic tx_mute_allow;
    logic hook_off_ctl;
    logic tone_hold_ctl;
    logic fast_osc_on;
    logic dial_irq_mask;
    logic dial_done_flag;
  } ctl_regs_t;

endpackage : dialer_pkg

/* testbench/dialer_checker.sv */
// Port-level assertions for the dialing sequencer.
// Bound into telephone_dialer; timing scales with its tick parameter.
`timescale 1ns/100ps
`default_nettype none
module dialer_checker
  import dialer_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic mclk,            // Clock
  input wire logic rst_n,           // Reset, active low
  input wire logic hreadyout,       // Slave ready
  input wire logic hresp,           // Response
  input wire logic [7:0] tone_out,  // Tone sample
  input wire logic pulse_dial_out,  // Loop pin
  input wire logic rx_mute_n,       // Receive mute
  input wire logic tx_mute_n,       // Transmit mute
  input wire logic dial_irq         // Interrupt
);
  // One tick of slack, the timebase phase is free
  localparam int QUIET_MIN = int'(TONE_GAP_MS + MUTE_TAIL_MS - 11'd1) * TICK_CYCLES_P;
  localparam int BRK_MIN = int'(PERIOD_20PPS_MS - MAKE_20PPS_40_MS - 11'd1) * TICK_CYCLES_P;
  localparam int MK_MIN = int'(MAKE_20PPS_33_MS - 11'd1) * TICK_CYCLES_P;
  logic [31:0] quiet_q, hi_q, lo_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_q <= '0;
      hi_q <= '0;
      lo_q <= '0;
    end else begin
      quiet_q <= (!tx_mute_n && tone_out == TONE_MID) ? quiet_q + 32'h1 : '0;
      hi_q <= pulse_dial_out ? hi_q + 32'h1 : '0;
      lo_q <= pulse_dial_out ? '0 : lo_q + 32'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence line_break_s;
    $fell(pulse_dial_out) && !rx_mute_n;
  endsequence
  sequence mute_tail_s;
    (!tx_mute_n) [*8];
  endsequence
  hresp_okay_a: assert property (hresp == 1'b0)
    else $error("Bus response not okay");
  ready_bound_a: assert property (!hreadyout |-> ##[1:8] hreadyout)
    else $error("Bus wait too long");
  tone_muted_a: assert property (tone_out != TONE_MID |-> !tx_mute_n)
    else $error("Tone without transmit mute");
  gap_quiet_a: assert property ($rose(tx_mute_n) |-> quiet_q >= QUIET_MIN)
    else $error("Silent gap or mute tail short");
  irq_tail_a: assert property ($rose(dial_irq) |-> mute_tail_s)
    else $error("Mute released at cycle end");
  break_len_a: assert property ($rose(pulse_dial_out) && !rx_mute_n |-> lo_q >= BRK_MIN)
    else $error("Break interval short");
  make_len_a: assert property (line_break_s |-> hi_q >= MK_MIN)
    else $error("Make interval short");
  break_mute_a: assert property (line_break_s |-> !tx_mute_n)
    else $error("Break without transmit mute");
endmodule : dialer_checker
bind telephone_dialer dialer_checker #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (.mclk, .rst_n,
  .hreadyout, .hresp, .tone_out, .pulse_dial_out, .rx_mute_n, .tx_mute_n, .dial_irq);
`default_nettype wire

/* testbench/line_model.sv */
// Line interface model: counts loop breaks and times make and break.
// Assumes the loop pin is synchronous to mclk; a muted break is a dial pulse.
`timescale 1ns/100ps
`default_nettype none
module line_model (
  input wire logic mclk,            // Clock
  input wire logic pulse_dial_out,  // Loop pin
  input wire logic rx_mute_n,       // Receive mute
  output var int breaks,            // Dial pulses seen
  output var int make_len,          // Last make, cycles
  output var int break_len          // Last break, cycles
);
  int hi = 0;
  int lo = 0;
  logic prev = 1'b0;
  initial breaks = 0;
  initial make_len = 0;
  initial break_len = 0;
  always @(posedge mclk) begin
    if (pulse_dial_out && !prev && !rx_mute_n) break_len = lo;
    if (!pulse_dial_out && prev && !rx_mute_n) begin
      breaks++;
      make_len = hi;
    end
    if (pulse_dial_out !== prev) begin
      hi = 0;
      lo = 0;
    end
    if (pulse_dial_out) hi++;
    else lo++;
    prev = pulse_dial_out;
  end
endmodule : line_model
`default_nettype wire

/* testbench/telephone_dialer_tb.sv */
// Self-checking bench for the dialing sequencer over AHB-Lite.
// Assumes a 10 cycle tick, so one ms is ten clocks.
`timescale 1ns/100ps
`default_nettype none
module telephone_dialer_tb;
  import dialer_pkg::*;
  localparam int T = 10;
  logic mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdp = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b000;
  wire logic hready, hreadyout, hresp, pulse_dial_out, rx_mute_n, tx_mute_n;
  wire logic fast_oscillator_en, dial_irq;
  wire logic [7:0] tone_out;
  wire logic [31:0] hrdata;
  int mismatches = 0, compares = 0, cyc = 0;
  int n, tn, nd, gc, per, mkms, gms, p0, brk, mk, bk;
  int ens[4] = '{3, 1, 2, 0};
  logic [7:0] ri[9] = '{IDX_PULSE_GAP, IDX_DIAL_CODE, IDX_TONE_HOLD, IDX_MUTE_ALLOW,
    IDX_DIAL_MODE, IDX_TONE_EN, IDX_HOOK, IDX_DONE_FLAG, 8'h00};
  logic [31:0] rv[9] = '{{28'h0, RST_PULSE_GAP}, {28'h0, RST_DIAL_CODE}, 32'h0, 32'h3,
    32'h0, 32'h3, 32'h0, 32'h0, 32'h0};
  logic [31:0] expq[$];
  assign hready = hreadyout;
  telephone_dialer #(.TICK_CYCLES_P(T)) u_dut (.mclk, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .tone_out,
    .pulse_dial_out, .rx_mute_n, .tx_mute_n, .fast_oscillator_en, .dial_irq);
  line_model u_line (.mclk, .pulse_dial_out, .rx_mute_n, .breaks(brk), .make_len(mk),
    .break_len(bk));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic close_out();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask : chk_rd
  task automatic chk_num(input int g, input int lo, input int hi);
    compares++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("[ERR] %0t count %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask : chk_num
  // Single transfer; a read notes its expected word for the monitor
  task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] d);
    haddr <= {22'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    hsel <= 1'b1;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    rdp <= !w;
    if (!w) expq.push_back(d);
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rdp <= 1'b0;
  endtask : bus
  task automatic wirq();
    n = 0;
    tn = 0;
    while (dial_irq !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      n++;
      if (tone_out !== TONE_MID) tn++;
    end
  endtask : wirq
  always @(posedge mclk) begin
    if (rdp && hreadyout === 1'b1 && expq.size() > 0) chk_rd(hrdata, expq.pop_front());
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    void'($urandom(32'hef653aa3));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk_rd({31'h0, pulse_dial_out}, 32'h0);
    for (int i = 0; i < 9; i++) bus(ri[i], 1'b0, rv[i]);
    bus(IDX_HOOK, 1'b1, 32'h1);
    bus(IDX_IRQ_MASK, 1'b1, 32'h1);
    bus(IDX_OSC_CTL, 1'b1, 32'h1);
    repeat (6 * T) @(posedge mclk);
    chk_rd({31'h0, fast_oscillator_en}, 32'h1);
    chk_rd({31'h0, pulse_dial_out}, 32'h1);
    bus(IDX_MUTE_ALLOW, 1'b1, 32'h1);
    repeat (2) @(posedge mclk);
    chk_rd({30'h0, rx_mute_n, tx_mute_n}, 32'h1);
    bus(IDX_MUTE_ALLOW, 1'b1, 32'h3);
    for (int i = 0; i < 4; i++) begin
      bus(IDX_TONE_EN, 1'b1, 32'(ens[i]));
      bus(IDX_DIAL_CODE, 1'b1, 32'($urandom_range(15, 1)));
      wirq();
      chk_num(n, 186 * T, 190 * T);
      chk_num(tn > 0, ens[i] != 0, ens[i] != 0);
      chk_rd({30'h0, rx_mute_n, tx_mute_n}, 32'h2);
      bus(IDX_DONE_FLAG, 1'b0, 32'h1);
      bus(IDX_DONE_FLAG, 1'b0, 32'h0);
      repeat (6 * T) @(posedge mclk);
      chk_rd({31'h0, tx_mute_n}, 32'h1);
    end
    bus(IDX_TONE_EN, 1'b1, 32'h3);
    bus(IDX_TONE_HOLD, 1'b1, 32'h8);
    bus(IDX_DIAL_CODE, 1'b1, 32'h5);
    repeat (300 * T) @(posedge mclk);
    chk_rd({30'h0, dial_irq, tx_mute_n}, 32'h0);
    bus(IDX_TONE_HOLD, 1'b1, 32'h0);
    wirq();
    chk_num(n, 92 * T, 97 * T);
    bus(IDX_DONE_FLAG, 1'b0, 32'h1);
    repeat (6 * T) @(posedge mclk);
    bus(IDX_TONE_HOLD, 1'b1, 32'h8);
    bus(IDX_DIAL_CODE, 1'b1, 32'hc);
    repeat (10 * T) @(posedge mclk);
    bus(IDX_TONE_HOLD, 1'b1, 32'h0);
    wirq();
    chk_num(n, 176 * T, 180 * T);
    repeat (6 * T) @(posedge mclk);
    // Flag left set: the next code write must not dial
    bus(IDX_DIAL_CODE, 1'b1, 32'h9);
    repeat (20 * T) @(posedge mclk);
    chk_rd({31'h0, tx_mute_n}, 32'h1);
    bus(IDX_DONE_FLAG, 1'b0, 32'h1);
    for (int k = 0; k < 4; k++) begin
      nd = (k == 3) ? 15 : int'($urandom_range(5, 2));
      gc = (k == 2) ? 8 : 1;
      gms = (k == 2) ? 750 : 94;
      per = k[0] ? 50 : 100;
      mkms = k[0] ? (k[1] ? 17 : 20) : (k[1] ? 33 : 40);
      bus(IDX_PULSE_GAP, 1'b1, 32'(gc));
      bus(IDX_DIAL_MODE, 1'b1, 32'h8 | 32'(k));
      p0 = brk;
      bus(IDX_DIAL_CODE, 1'b1, 32'(nd));
      wirq();
      chk_rd({30'h0, rx_mute_n, tx_mute_n}, 32'h0);
      chk_num(brk - p0, nd, nd);
      chk_num(mk, (mkms - 1) * T, (mkms + 1) * T);
      chk_num(bk, (per - mkms - 1) * T, (per - mkms + 1) * T);
      chk_num(n, (nd * per + gms - 2) * T, (nd * per + gms + 2) * T);
      bus(IDX_DONE_FLAG, 1'b0, 32'h1);
      repeat (6 * T) @(posedge mclk);
    end
    close_out();
  end
endmodule : telephone_dialer_tb
`default_nettype wire
